// ### design/rtd_top.v
// Chosen here: the register offsets and register access over Avalon-MM.
`timescale 1ns/100ps
`include "rtd_regs.vh"

// How it works
// - seconds hold BCD 00..59 in bits 6-0, bit 7 reads zero.
// - minutes hold BCD 00..59 in bits 6-0, in both banks.
// - 24-hour format: bits 5-0 BCD hour 0..23, bits 7-6 read zero.
// - 12-hour format: bit 5 is PM flag, bits 4-0 BCD hour 0..11.
// - weekday code in bits 2-0, Sunday 000 to Saturday 110, rest zero.
// - seconds exist only in the clock bank; alarm bank reads zero there.
// - bank select bit steers shared addresses to clock or alarm bank.
module rtd_top (
    input  wire        CORE_CLK,
    input  wire        RESETN,
    input  wire        CLK_EN,
    input  wire [5:0]  AVS_ADDRESS,
    input  wire        AVS_READ,
    input  wire        AVS_WRITE,
    input  wire [3:0]  AVS_BYTEENABLE,
    input  wire [31:0] AVS_WRITEDATA,
    output reg  [31:0] AVS_READDATA,
    output wire        AVS_WAITREQUEST,
    output wire        HR_FORMAT_24
);
    wire [3:0]                idx = AVS_ADDRESS[5:2];
    wire                      be0 = AVS_BYTEENABLE[0];
    wire                      wr  = AVS_WRITE && !AVS_WAITREQUEST && be0;

    reg                       bank_q;
    reg                       fmt_q;
    reg  [1:0]                rd_cnt_q;
    reg  [1:0]                rd_cnt_d;
    reg  [31:0]               rdata_d;
    reg                       wr_sec;
    reg                       wr_min;
    reg                       wr_hour;
    reg                       wr_dow;
    wire [`RTD_SEC_W-1:0]     sec_r;
    wire [`RTD_MIN_W-1:0]     min_r;
    wire [`RTD_HOUR_W-1:0]    hour_r;
    wire [`RTD_DOW_W-1:0]     dow_r;

    // write strobes, address decode
    always @* begin
        wr_sec  = 1'b0;
        wr_min  = 1'b0;
        wr_hour = 1'b0;
        wr_dow  = 1'b0;
        if (idx == `RTD_IDX_SEC) begin
            wr_sec = wr;
        end else if (idx == `RTD_IDX_MIN) begin
            wr_min = wr;
        end else if (idx == `RTD_IDX_HOUR) begin
            wr_hour = wr;
        end else if (idx == `RTD_IDX_DOW) begin
            wr_dow = wr;
        end
    end

    // seconds: clock bank only, fields never reset
    rtd_field #(.W(`RTD_SEC_W), .HAS_ALM(0)) u_sec (
        .clk   (CORE_CLK),
        .ce    (CLK_EN),
        .wr    (wr_sec),
        .bank  (bank_q),
        .wdata (AVS_WRITEDATA[`RTD_SEC_W-1:0]),
        .rdata (sec_r)
    );

    // minutes in both banks
    rtd_field #(.W(`RTD_MIN_W), .HAS_ALM(1)) u_min (
        .clk   (CORE_CLK),
        .ce    (CLK_EN),
        .wr    (wr_min),
        .bank  (bank_q),
        .wdata (AVS_WRITEDATA[`RTD_MIN_W-1:0]),
        .rdata (min_r)
    );

    // hour bits 5-0, meaning set by format flag
    rtd_field #(.W(`RTD_HOUR_W), .HAS_ALM(1)) u_hour (
        .clk   (CORE_CLK),
        .ce    (CLK_EN),
        .wr    (wr_hour),
        .bank  (bank_q),
        .wdata (AVS_WRITEDATA[`RTD_HOUR_W-1:0]),
        .rdata (hour_r)
    );

    // weekday
    rtd_field #(.W(`RTD_DOW_W), .HAS_ALM(1)) u_dow (
        .clk   (CORE_CLK),
        .ce    (CLK_EN),
        .wr    (wr_dow),
        .bank  (bank_q),
        .wdata (AVS_WRITEDATA[`RTD_DOW_W-1:0]),
        .rdata (dow_r)
    );

    // bank select and format flag live in reset control state
    always @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            bank_q <= `RTD_BANK_RST;
            fmt_q  <= `RTD_FMT_RST;
        end else if (CLK_EN) begin
            if (wr && idx == `RTD_IDX_BANK)
                bank_q <= AVS_WRITEDATA[`RTD_BANK_BIT];
            if (wr && idx == `RTD_IDX_MONFMT && bank_q)
                fmt_q <= AVS_WRITEDATA[`RTD_FMT_BIT];
        end
    end

    assign HR_FORMAT_24 = fmt_q;

    // read data mux, upper bits zero
    always @* begin
        rdata_d = 32'h0000_0000;
        if (idx == `RTD_IDX_SEC) begin
            rdata_d[`RTD_SEC_W-1:0] = sec_r;
        end else if (idx == `RTD_IDX_MIN) begin
            rdata_d[`RTD_MIN_W-1:0] = min_r;
        end else if (idx == `RTD_IDX_HOUR) begin
            rdata_d[`RTD_HOUR_W-1:0] = hour_r;
        end else if (idx == `RTD_IDX_DOW) begin
            rdata_d[`RTD_DOW_W-1:0] = dow_r;
        end else if (idx == `RTD_IDX_MONFMT) begin
            rdata_d[`RTD_FMT_BIT] = bank_q & fmt_q;
        end else if (idx == `RTD_IDX_BANK) begin
            rdata_d[`RTD_BANK_BIT] = bank_q;
        end
    end

    // reads wait one cycle, writes complete at once
    always @* begin
        rd_cnt_d = rd_cnt_q;
        if (AVS_READ) begin
            if (rd_cnt_q != 2'h0)
                rd_cnt_d = rd_cnt_q - 2'h1;
            else
                rd_cnt_d = `RTD_RD_WAIT;
        end else begin
            rd_cnt_d = `RTD_RD_WAIT;
        end
    end

    assign AVS_WAITREQUEST = AVS_READ && (rd_cnt_q != 2'h0);

    always @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            rd_cnt_q     <= `RTD_RD_WAIT;
            AVS_READDATA <= 32'h0000_0000;
        end else if (CLK_EN) begin
            rd_cnt_q <= rd_cnt_d;
            if (AVS_READ && rd_cnt_q != 2'h0)
                AVS_READDATA <= rdata_d;
        end
    end
endmodule // rtd_top

// ### design/rtd_regs.vh
`ifndef RTD_REGS_VH
`define RTD_REGS_VH

// register indices, byte address is four times the index
`define RTD_IDX_SEC      4'h0
`define RTD_IDX_MIN      4'h1
`define RTD_IDX_HOUR     4'h2
`define RTD_IDX_DOW      4'h4
`define RTD_IDX_MONFMT   4'h6
`define RTD_IDX_BANK     4'h8

// field widths and positions
`define RTD_SEC_W        7
`define RTD_MIN_W        7
`define RTD_HOUR_W       6
`define RTD_DOW_W        3
`define RTD_FMT_BIT      0
`define RTD_BANK_BIT     0
`define RTD_HOUR_PM_BIT  5

// reset value of the bank select register (clock bank)
`define RTD_BANK_RST     1'h0
// reset value of the hour format flag (arbitrary, 12-hour)
`define RTD_FMT_RST      1'h0

// read wait states before waitrequest drops
`define RTD_RD_WAIT      2'h1

`endif

// ### design/rtd_field.v
`timescale 1ns/100ps
// one time field with a clock copy and an alarm copy, bank chosen by select
module rtd_field #(
    parameter W       = 7,
    parameter HAS_ALM = 1
) (
    input  wire         clk,
    input  wire         ce,
    input  wire         wr,
    input  wire         bank,
    input  wire [W-1:0] wdata,
    output wire [W-1:0] rdata
);
    reg [W-1:0] clk_q;
    reg [W-1:0] alm_q;

    // no reset: contents stay arbitrary until written
    always @(posedge clk) begin
        if (ce && wr && !bank)
            clk_q <= wdata;
    end

    generate
        if (HAS_ALM != 0) begin : g_alm
            always @(posedge clk) begin
                if (ce && wr && bank)
                    alm_q <= wdata;
            end
            assign rdata = bank ? alm_q : clk_q;
        end else begin : g_noalm
            always @(posedge clk) begin
                alm_q <= {W{1'b0}};
            end
            assign rdata = bank ? {W{1'b0}} : clk_q;
        end
    endgenerate
endmodule // rtd_field

// ### dv/rtd_props.sv
`timescale 1ns/100ps
module rtd_props (
    input wire        CORE_CLK,
    input wire        RESETN,
    input wire [5:0]  AVS_ADDRESS,
    input wire        AVS_READ,
    input wire        AVS_WRITE,
    input wire [31:0] AVS_READDATA,
    input wire        AVS_WAITREQUEST,
    input wire        HR_FORMAT_24
);
    wire       rd_ok = AVS_READ && !AVS_WAITREQUEST;
    wire [3:0] ix    = AVS_ADDRESS[5:2];
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);
    rd_wait_a: assert property ($rose(AVS_READ) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
        else $error("read wait");
    wr_nowait_a: assert property (AVS_WRITE |-> !AVS_WAITREQUEST)
        else $error("write wait");
    sec_top_a: assert property (rd_ok && ix == 4'h0 |-> AVS_READDATA[31:7] == 25'h0)
        else $error("sec top");
    min_top_a: assert property (rd_ok && ix == 4'h1 |-> AVS_READDATA[31:7] == 25'h0)
        else $error("min top");
    hour_top_a: assert property (rd_ok && ix == 4'h2 |-> AVS_READDATA[31:6] == 26'h0)
        else $error("hour top");
    dow_top_a: assert property (rd_ok && ix == 4'h4 |-> AVS_READDATA[31:3] == 29'h0)
        else $error("dow top");
    fmt_src_a: assert property ($changed(HR_FORMAT_24) |-> $past(AVS_WRITE && ix == 4'h6))
        else $error("format change");
    rdata_hold_a: assert property (!AVS_READ |=> $stable(AVS_READDATA))
        else $error("rdata moved");
    cover property (rd_ok && ix == 4'h0);
    cover property ($rose(HR_FORMAT_24));
    cover property (rd_ok && ix == 4'h3);
endmodule // rtd_props

bind rtd_top rtd_props i_props (.*);

// ### dv/rtd_tb.sv
`timescale 1ns/100ps
module tb;
    reg         CORE_CLK       = 1'h0;
    reg         RESETN         = 1'h0;
    reg         CLK_EN         = 1'h1;
    reg  [5:0]  AVS_ADDRESS    = 6'h0;
    reg         AVS_READ       = 1'h0;
    reg         AVS_WRITE      = 1'h0;
    reg  [3:0]  AVS_BYTEENABLE = 4'hF;
    reg  [31:0] AVS_WRITEDATA  = 32'h0;
    wire [31:0] AVS_READDATA;
    wire        AVS_WAITREQUEST;
    wire        HR_FORMAT_24;
    int         err_count      = 0;
    int         checks         = 0;
    rtd_top i_dut (
        .CORE_CLK        (CORE_CLK),
        .RESETN          (RESETN),
        .CLK_EN          (CLK_EN),
        .AVS_ADDRESS     (AVS_ADDRESS),
        .AVS_READ        (AVS_READ),
        .AVS_WRITE       (AVS_WRITE),
        .AVS_BYTEENABLE  (AVS_BYTEENABLE),
        .AVS_WRITEDATA   (AVS_WRITEDATA),
        .AVS_READDATA    (AVS_READDATA),
        .AVS_WAITREQUEST (AVS_WAITREQUEST),
        .HR_FORMAT_24    (HR_FORMAT_24)
    );
    always #25 CORE_CLK = ~CORE_CLK;
    task ck(input [31:0] got, input [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("FAIL %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // read compares against d
    task bus(input rd, input [3:0] i, input [7:0] d);
        @(posedge CORE_CLK);
        AVS_ADDRESS <= {i, 2'h0};
        AVS_READ <= rd;
        AVS_WRITE <= !rd;
        AVS_WRITEDATA <= {24'h0, d};
        do @(posedge CORE_CLK); while (AVS_WAITREQUEST !== 1'h0);
        if (rd) ck(AVS_READDATA, {24'h0, d});
        AVS_READ <= 1'h0;
        AVS_WRITE <= 1'h0;
    endtask
    task t_time;
        // legal codes only
        bus(0, 4'h0, 8'h59);
        bus(0, 4'h1, 8'h59);
        bus(1, 4'h0, 8'h59);
        bus(1, 4'h0, 8'h59);
        bus(1, 4'h1, 8'h59);
        for (int k = 0; k < 7; k++) begin
            bus(0, 4'h4, k[7:0]);
            bus(1, 4'h4, k[7:0]);
        end
        $display("t_time end");
    endtask
    task t_bank;
        bus(0, 4'h8, 8'h01);
        bus(0, 4'h0, 8'h12);
        bus(1, 4'h0, 8'h00);
        bus(0, 4'h1, 8'h30);
        bus(1, 4'h1, 8'h30);
        // format set while alarm bank is selected
        bus(0, 4'h6, 8'h01);
        bus(0, 4'h2, 8'h23);
        bus(1, 4'h2, 8'h23);
        ck({31'h0, HR_FORMAT_24}, 32'h1);
        bus(0, 4'h8, 8'h00);
        bus(1, 4'h1, 8'h59);
        bus(0, 4'h3, 8'h45);
        bus(1, 4'h3, 8'h00);
        $display("t_bank end");
    endtask
    task t_h12;
        bus(0, 4'h8, 8'h01);
        bus(0, 4'h6, 8'h00);
        bus(0, 4'h8, 8'h00);
        bus(0, 4'h2, 8'h31);
        bus(1, 4'h2, 8'h31);
        ck({31'h0, HR_FORMAT_24}, 32'h0);
        $display("t_h12 end");
    endtask
    task t_rst;
        @(posedge CORE_CLK);
        RESETN <= 1'h0;
        repeat (2) @(posedge CORE_CLK);
        RESETN <= 1'h1;
        bus(1, 4'h0, 8'h59);
        bus(1, 4'h2, 8'h31);
        // clock enable low: write must be dropped
        CLK_EN <= 1'h0;
        bus(0, 4'h1, 8'h00);
        CLK_EN <= 1'h1;
        bus(1, 4'h1, 8'h59);
        $display("t_rst end");
    endtask
    task report_and_stop;
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge CORE_CLK);
        RESETN <= 1'h1;
        t_time;
        t_bank;
        t_h12;
        t_rst;
        report_and_stop;
    end
    initial begin
        #200000;
        err_count++;
        report_and_stop;
    end
endmodule // tb
